// File: hw/adc_seq_params.svh
// constants for the converter sequence controller
// included by the controller; definitions only
`ifndef ADC_SEQ_PARAMS_SVH
`define ADC_SEQ_PARAMS_SVH
`define ADR_RESULT_LOW 8'hBA
`define ADR_RESULT_HIGH 8'hBB
`define ADR_PIN_ENABLE 8'hBC
`define ADR_CTRL_ONE 8'hB4
`define ADR_SEQ_CFG 8'hB5
`define ADR_EXTRA_CFG 8'hB6
`define RST_BYTE 8'h00
`define CLK_DIV 3'h6
`define CLK_DIV_LAST 3'h5
`define SETTLE_TICKS 10'h010
`define DIFF_FIRST 4'h8
`define SPECIAL_FIRST 4'hC
`define TRIG_EXT 2'h0
`define TRIG_CHAIN 2'h1
`define TRIG_TIMER 2'h2
`define TRIG_GO 2'h3
`define FULL_POS 12'h7FF
`define FULL_NEG 12'h800
`endif

// File: hw/adc_seq_pkg.sv
// types shared by the converter sequence controller
// no assumptions beyond the params header
package adc_seq_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SETTLE = 2'b01,
    ST_FILTER = 2'b10,
    ST_DONE = 2'b11
  } conv_state_t;
endpackage

// File: hw/adc_sequence_controller.sv
// converter sequence controller: registers, sequencing, timing and triggers
// assumes synchronous trigger inputs and a behavioural sample source
//
// Overview of operation
// - pin usable as sequence input only when its enable mask bit is one; reset disables all
// - sequence skips inputs not enabled in the mask
// - differential pair converted in a sequence only when both pins are enabled
// - select codes: 0-7 single, 8-11 pairs, 12-15 internal sources
// - select below 8 converts inputs zero up to programmed input
// - 8-11 runs pairs up to programmed pair; higher gives one conversion
// - pairs are 0/1, 2/3, 4/5, 6/7, difference converted
// - done flag set on any conversion end, cleared by high byte read
// - go bit starts sequence with trigger 11 when idle; clears at completion
// - trigger choice picks pin edge, chaining, timer compare, or go bit
// - any write to extra config requests one extra conversion, same coding
// - extra runs after running sequence, or immediately when idle
// - with no pin enabled, select field and done flag still update
// - results two's complement, left aligned; 2047 and -2048 at twelve bits
// - select reads the written code after a sequence; below 12 this is written plus one
// - after extra conversion select field takes the extra channel value
// - converter clock is system clock divided by six
// - conversion takes 16 settle ticks plus decimation rate ticks
// - interrupt only on extra conversion completion
// - per-channel triggers fire for sequence samples only, not for extra conversions
// - any-channel trigger on sequence samples, never on extra conversions
// - done flag stays set if result not yet read
// - high byte holds result bits eleven to four
`timescale 1ns/1ps
`include "adc_seq_params.svh"
module adc_sequence_controller (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // register port
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regRdData,
  // start sources
  input wire logic externalStartPin,
  input wire logic timerOneCh0Compare,
  // sample source: signed sample of the selected channel
  input wire logic signed [11:0] sampleValue,
  output logic [3:0] sampleChannel,
  output logic [1:0] sampleReference,
  // events
  output logic convIrq,
  output logic [8:0] channelDmaTrigger,
  output logic anyChannelDmaTrigger
);
  adc_seq_pkg::conv_state_t state_q;
  logic [7:0] pinEnable_q;
  logic [1:0] trigChoice_q;
  logic goBit_q;
  logic done_q;
  logic [1:0] seqRef_q;
  logic [1:0] seqDiv_q;
  logic [3:0] seqSel_q;
  logic [3:0] seqEnd_q;
  logic [1:0] extRef_q;
  logic [1:0] extDiv_q;
  logic [3:0] extSel_q;
  logic extPending_q;
  logic inExtra_q;
  logic seqActive_q;
  logic [3:0] curCh_q;
  logic [2:0] divCnt_q;
  logic [9:0] tickCnt_q;
  logic [11:0] result_q;
  logic extPin_q;
  logic chainReq_q;
  logic tick;
  logic wrExtra;
  logic rdHigh;
  logic startReq;
  logic [1:0] curDiv;
  logic [9:0] filterTicks;
  logic [3:0] lastCh;
  logic [3:0] nextCh;
  logic seqLast;
  logic chUsable;
  logic convEnd;
  logic skipEnd;
  logic seqDone;
  logic filterLast;
  logic busy;

  assign wrExtra = regWrite && (regAddr == `ADR_EXTRA_CFG);
  assign rdHigh = regRead && (regAddr == `ADR_RESULT_HIGH);
  assign tick = (divCnt_q == `CLK_DIV_LAST);

  // sequence end: last code for a sequence, the code itself for specials
  assign lastCh = seqEnd_q;
  assign seqLast = inExtra_q || (curCh_q >= lastCh) || (lastCh >= `SPECIAL_FIRST);
  assign nextCh = curCh_q + 4'h1;

  // pin gating of the current channel
  always_comb
  begin
    chUsable = 1'b1;
    if (curCh_q < `DIFF_FIRST)
      chUsable = pinEnable_q[curCh_q[2:0]];
    else if (curCh_q < `SPECIAL_FIRST)
      chUsable = pinEnable_q[{curCh_q[1:0], 1'b0}] && pinEnable_q[{curCh_q[1:0], 1'b1}];
  end

  assign curDiv = inExtra_q ? extDiv_q : seqDiv_q;
  // decimation rates 64, 128, 256, 512
  assign filterTicks = 10'h040 << curDiv;

  always_comb
  begin
    startReq = 1'b0;
    case (trigChoice_q)
      `TRIG_EXT: startReq = externalStartPin && !extPin_q;
      `TRIG_CHAIN: startReq = chainReq_q;
      `TRIG_TIMER: startReq = timerOneCh0Compare;
      `TRIG_GO: startReq = goBit_q;
      default: startReq = 1'b0;
    endcase
  end

  assign convEnd = (state_q == adc_seq_pkg::ST_DONE);

  // sequence completion: last conversion ends, or the last input is skipped
  assign skipEnd = (state_q == adc_seq_pkg::ST_IDLE) && seqActive_q && !chUsable && seqLast;
  assign seqDone = skipEnd || (convEnd && !inExtra_q && seqLast);
  // last filter tick: result capture and event pulses share it
  assign filterLast = (state_q == adc_seq_pkg::ST_FILTER) && tick &&
    (tickCnt_q == filterTicks - 10'h001);
  // an extra conversion counts as running too
  assign busy = (state_q != adc_seq_pkg::ST_IDLE) || seqActive_q;

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      divCnt_q <= 3'h0;
    else if (tick)
      divCnt_q <= 3'h0;
    else
      divCnt_q <= divCnt_q + 3'h1;
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      extPin_q <= 1'b0;
    else
      extPin_q <= externalStartPin;
  end

  // conversion engine
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_q <= adc_seq_pkg::ST_IDLE;
      curCh_q <= 4'h0;
      tickCnt_q <= 10'h000;
      inExtra_q <= 1'b0;
      seqActive_q <= 1'b0;
      chainReq_q <= 1'b0;
    end
    else
    begin
      chainReq_q <= 1'b0;
      case (state_q)
        adc_seq_pkg::ST_IDLE:
        begin
          tickCnt_q <= 10'h000;
          if (seqActive_q && !chUsable)
          begin
            // unusable inputs are skipped without conversion time
            if (seqLast)
            begin
              seqActive_q <= 1'b0;
              chainReq_q <= 1'b1;
            end
            else
              curCh_q <= nextCh;
          end
          else if (seqActive_q)
            state_q <= adc_seq_pkg::ST_SETTLE;
          else if (extPending_q)
          begin
            inExtra_q <= 1'b1;
            curCh_q <= extSel_q;
            state_q <= adc_seq_pkg::ST_SETTLE;
          end
          else if (startReq)
          begin
            seqActive_q <= 1'b1;
            inExtra_q <= 1'b0;
            // readback field moves after each run; the written end point does not
            if (seqEnd_q < `DIFF_FIRST)
              curCh_q <= 4'h0;
            else if (seqEnd_q < `SPECIAL_FIRST)
              curCh_q <= `DIFF_FIRST;
            else
              curCh_q <= seqEnd_q;
          end
        end
        adc_seq_pkg::ST_SETTLE:
          if (tick)
          begin
            if (tickCnt_q == `SETTLE_TICKS - 10'h001)
            begin
              tickCnt_q <= 10'h000;
              state_q <= adc_seq_pkg::ST_FILTER;
            end
            else
              tickCnt_q <= tickCnt_q + 10'h001;
          end
        adc_seq_pkg::ST_FILTER:
          if (tick)
          begin
            if (tickCnt_q == filterTicks - 10'h001)
              state_q <= adc_seq_pkg::ST_DONE;
            else
              tickCnt_q <= tickCnt_q + 10'h001;
          end
        adc_seq_pkg::ST_DONE:
        begin
          state_q <= adc_seq_pkg::ST_IDLE;
          if (inExtra_q)
            inExtra_q <= 1'b0;
          else if (seqLast)
          begin
            seqActive_q <= 1'b0;
            chainReq_q <= 1'b1;
          end
          else
            curCh_q <= nextCh;
        end
        default: state_q <= adc_seq_pkg::ST_IDLE;
      endcase
    end
  end

  // result capture, left aligned two's complement
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      result_q <= 12'h000;
    else if (filterLast)
    begin
      if (curCh_q < `DIFF_FIRST && sampleValue[11])
        result_q <= 12'h000; // single-ended never negative
      else
        result_q <= sampleValue;
    end
  end

  // event pulses, in the cycle the result becomes readable
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      convIrq <= 1'b0;
      channelDmaTrigger <= 9'h000;
      anyChannelDmaTrigger <= 1'b0;
    end
    else
    begin
      convIrq <= 1'b0;
      channelDmaTrigger <= 9'h000;
      anyChannelDmaTrigger <= 1'b0;
      if (filterLast)
      begin
        if (inExtra_q)
          convIrq <= 1'b1;
        else
        begin
          // triggers 20..27 map to channel codes 0..7 of the sequence, trigger 28 to codes 8..15
          if (curCh_q <= `DIFF_FIRST)
            channelDmaTrigger[curCh_q] <= 1'b1;
          else
            channelDmaTrigger[8] <= 1'b1;
          anyChannelDmaTrigger <= 1'b1;
        end
      end
    end
  end

  // done flag: set wins over read clear
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      done_q <= 1'b0;
    else if (convEnd || skipEnd)
      done_q <= 1'b1;
    else if (rdHigh)
      done_q <= 1'b0;
  end

  // register writes
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pinEnable_q <= `RST_BYTE;
      trigChoice_q <= `TRIG_GO;
      goBit_q <= 1'b0;
      seqRef_q <= 2'h0;
      seqDiv_q <= 2'h0;
      seqSel_q <= 4'h0;
      seqEnd_q <= 4'h0;
      extRef_q <= 2'h0;
      extDiv_q <= 2'h0;
      extSel_q <= 4'h0;
      extPending_q <= 1'b0;
    end
    else
    begin
      if (regWrite && regAddr == `ADR_PIN_ENABLE)
        pinEnable_q <= regWrData;
      if (regWrite && regAddr == `ADR_CTRL_ONE)
        trigChoice_q <= regWrData[5:4];
      // go stays readable for the whole run and drops with its completion
      if (regWrite && regAddr == `ADR_CTRL_ONE && regWrData[6] && !busy)
        goBit_q <= 1'b1;
      else if (seqDone)
        goBit_q <= 1'b0;
      // reference and decimation assumed stable while busy
      if (regWrite && regAddr == `ADR_SEQ_CFG)
      begin
        seqRef_q <= regWrData[7:6];
        seqDiv_q <= regWrData[5:4];
        seqSel_q <= regWrData[3:0];
        seqEnd_q <= regWrData[3:0];
      end
      else if (convEnd && inExtra_q)
        seqSel_q <= extSel_q;
      else if (convEnd || skipEnd)
        seqSel_q <= (seqEnd_q < `SPECIAL_FIRST) ? seqEnd_q + 4'h1 : seqEnd_q;
      if (wrExtra)
      begin
        extRef_q <= regWrData[7:6];
        extDiv_q <= regWrData[5:4];
        extSel_q <= regWrData[3:0];
        extPending_q <= 1'b1;
      end
      else if (state_q == adc_seq_pkg::ST_IDLE && !seqActive_q && extPending_q)
        extPending_q <= 1'b0;
    end
  end

  assign sampleChannel = curCh_q;
  assign sampleReference = inExtra_q ? extRef_q : seqRef_q;

  // read data one cycle after the strobe
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      regRdData <= `RST_BYTE;
    else if (regRead)
    begin
      case (regAddr)
        `ADR_RESULT_LOW: regRdData <= {result_q[3:0], 4'h0};
        `ADR_RESULT_HIGH: regRdData <= result_q[11:4];
        `ADR_PIN_ENABLE: regRdData <= pinEnable_q;
        `ADR_CTRL_ONE: regRdData <= {done_q, goBit_q, trigChoice_q, 4'h0};
        `ADR_SEQ_CFG: regRdData <= {seqRef_q, seqDiv_q, seqSel_q};
        `ADR_EXTRA_CFG: regRdData <= {extRef_q, extDiv_q, extSel_q};
        default: regRdData <= `RST_BYTE;
      endcase
    end
    else
      regRdData <= `RST_BYTE;
  end
endmodule // adc_sequence_controller

// File: verif/adc_sample_source.sv
// sample source standing in for the analog front end
// combinational: answers at once for the channel shown
`timescale 1ns/1ps
module adc_sample_source (
  // channel asked for
  input wire logic [3:0] sampleChannel,
  // signed sample returned
  output logic signed [11:0] sampleValue
);
  always_comb
  begin
    case (sampleChannel)
      4'h2: sampleValue = 12'h7FF;
      4'h8: sampleValue = 12'h800;
      default: sampleValue = {1'b0, sampleChannel[2:0], 8'h3C};
    endcase
  end
endmodule // adc_sample_source

// File: verif/adc_seq_checker_sva.sv
// checker for the converter sequence controller
// bound to the controller top; sees its ports only
`timescale 1ns/1ps
module adc_seq_checker (
  // watched ports
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] regAddr,
  input wire logic regRead,
  input wire logic [7:0] regRdData,
  input wire logic convIrq,
  input wire logic [8:0] channelDmaTrigger,
  input wire logic anyChannelDmaTrigger
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // a conversion lasts hundreds of cycles, so eight is a safe floor
  sequence quiet8;
    !anyChannelDmaTrigger [*8];
  endsequence
  sequence rdOf(logic [7:0] a);
    regRead && regAddr == a;
  endsequence
  a_irq_no_dma: assert property (
    convIrq |-> !anyChannelDmaTrigger && channelDmaTrigger == 9'h000)
    else $error("dma trigger beside irq");
  a_irq_one_cycle: assert property (convIrq |=> !convIrq)
    else $error("irq longer than one cycle");
  a_chan_onehot: assert property (
    anyChannelDmaTrigger |-> $onehot(channelDmaTrigger))
    else $error("channel trigger not one-hot");
  a_chan_needs_any: assert property (
    (|channelDmaTrigger) |-> anyChannelDmaTrigger)
    else $error("channel trigger without any trigger");
  a_chan_pulse: assert property (
    (|channelDmaTrigger) |=> channelDmaTrigger == 9'h000)
    else $error("channel trigger held");
  a_any_spacing: assert property (anyChannelDmaTrigger |=> quiet8)
    else $error("samples too close");
  a_rd_idle_zero: assert property (!regRead |=> regRdData == 8'h00)
    else $error("read data without read");
  a_rd_low_nibble: assert property (
    rdOf(8'hBA) |=> regRdData[3:0] == 4'h0)
    else $error("result low nibble not zero");
  a_rd_unmapped: assert property (rdOf(8'h00) |=> regRdData == 8'h00)
    else $error("unmapped read not zero");
endmodule // adc_seq_checker
bind adc_sequence_controller adc_seq_checker adc_seq_checker_i (
  .clk(clk), .sys_rst(sys_rst), .regAddr(regAddr), .regRead(regRead),
  .regRdData(regRdData), .convIrq(convIrq), .channelDmaTrigger(channelDmaTrigger),
  .anyChannelDmaTrigger(anyChannelDmaTrigger));

// File: verif/adc_sequence_controller_tb.sv
// self-checking bench for the converter sequence controller
// assumes the bound checker and the sample source model
`timescale 1ns/1ps
module adc_sequence_controller_tb;
  logic clk, sysRst, regWrite, regRead, extPin, timerCmp, rdSeen;
  logic noiseOn, pinLevel;
  logic [1:0] sampleRef;
  logic [7:0] regAddr, regWrData, regRdData;
  logic [3:0] sampleChannel;
  logic signed [11:0] sampleValue;
  logic convIrq, anyTrig;
  logic [8:0] chanTrig;
  logic [16:0] lfsr = 17'h15794;
  logic [7:0] rdQ[$];
  logic [11:0] evQ[$];
  int errors, checksDone, cycN;
  adc_sequence_controller adc_sequence_controller_i (
    .clk(clk), .sys_rst(sysRst), .regAddr(regAddr), .regWrData(regWrData),
    .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
    .externalStartPin(extPin), .timerOneCh0Compare(timerCmp),
    .sampleValue(sampleValue), .sampleChannel(sampleChannel), .sampleReference(sampleRef),
    .convIrq(convIrq), .channelDmaTrigger(chanTrig), .anyChannelDmaTrigger(anyTrig));
  adc_sample_source adc_sample_source_i (.sampleChannel(sampleChannel),
    .sampleValue(sampleValue));
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  function automatic logic [16:0] lfsrNext(input logic [16:0] v);
    return {v[15:0], v[16] ^ v[13]};
  endfunction
  // pin noise only while the trigger choice ignores the pin
  always @(posedge clk)
  begin
    lfsr <= lfsrNext(lfsr);
    extPin <= noiseOn ? lfsr[0] : pinLevel;
  end
  task automatic check(input string what, input logic [12:0] e, input logic [12:0] got);
    checksDone++;
    if (got !== e)
    begin
      errors++;
      $display("mismatch %s exp %h got %h", what, e, got);
    end
  endtask
  always @(posedge clk)
  begin
    if (rdSeen)
      check("read", rdQ.size() ? {5'h00, rdQ.pop_front()} : 13'h1FFF,
        {5'h00, regRdData});
    if (anyTrig || convIrq)
      check("event", evQ.size() ? {evQ[0], ~evQ[0][9]} : 13'h1FFF,
        {sampleRef, convIrq, chanTrig, anyTrig});
    if ((anyTrig || convIrq) && evQ.size())
      void'(evQ.pop_front());
    rdSeen <= regRead && !sysRst;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    regRead <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    rdQ.push_back(e);
    regAddr <= a;
    regWrite <= 1'b0;
    regRead <= 1'b1;
    @(posedge clk);
  endtask
  task automatic closeOut();
    $display("checks %0d mismatches %0d", checksDone, errors);
    if (errors == 0 && checksDone > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic drain(input string name);
    int n;
    n = 0;
    regWrite <= 1'b0;
    regRead <= 1'b0;
    while (evQ.size() != 0 && n < 4000)
    begin
      @(posedge clk);
      n++;
    end
    if (n == 4000)
    begin
      errors++;
      $display("mismatch wait %s exp 0 got %0d", name, evQ.size());
      closeOut();
    end
    repeat (4) @(posedge clk);
    $display("test %s done", name);
  endtask
  initial
  begin
    {regWrite, regRead, timerCmp, pinLevel} = 4'h0;
    noiseOn = 1'b1;
    regAddr = 8'h00;
    regWrData = 8'h00;
    sysRst = 1'b1;
    repeat (8) @(posedge clk);
    sysRst <= 1'b0;
    @(posedge clk);
    rd(8'hB4, 8'h30);
    rd(8'hBC, 8'h00);
    rd(8'hBB, 8'h00);
    rd(8'h00, 8'h00);
    drain("reset");
    wr(8'hBC, 8'h05);
    wr(8'hB5, 8'h02);
    evQ.push_back(12'h001);
    evQ.push_back(12'h004);
    wr(8'hB4, 8'h70);
    rd(8'hB5, 8'h02);
    rd(8'hBC, 8'h05);
    rd(8'hB4, 8'h70);
    drain("seq_single");
    rd(8'hB5, 8'h03);
    rd(8'hB4, 8'hB0);
    rd(8'hBB, 8'h7F);
    rd(8'hBA, 8'hF0);
    rd(8'hB4, 8'h30);
    wr(8'hBC, 8'h07);
    wr(8'hB5, 8'h09);
    wr(8'hB4, 8'h20);
    evQ.push_back(12'h100);
    regWrite <= 1'b0;
    timerCmp <= 1'b1;
    @(posedge clk);
    timerCmp <= 1'b0;
    drain("seq_diff");
    rd(8'hB5, 8'h0A);
    rd(8'hB4, 8'hA0);
    rd(8'hBB, 8'h80);
    wr(8'hBC, 8'h00);
    wr(8'hB5, 8'h04);
    wr(8'hB4, 8'h70);
    drain("no_pins");
    repeat (20) @(posedge clk);
    rd(8'hB5, 8'h05);
    rd(8'hB4, 8'hB0);
    rd(8'hBB, 8'h80);
    wr(8'hBC, 8'hFF);
    evQ.push_back(12'hE00);
    wr(8'hB6, 8'hC3);
    drain("extra_idle");
    rd(8'hB6, 8'hC3);
    rd(8'hB5, 8'h03);
    rd(8'hBB, 8'h33);
    rd(8'hBA, 8'hC0);
    wr(8'hB5, 8'h00);
    evQ.push_back(12'h001);
    evQ.push_back(12'h200);
    wr(8'hB4, 8'h70);
    wr(8'hB6, 8'h0C);
    drain("extra_busy");
    rd(8'hB5, 8'h0C);
    // pin start: quiet pin, one rising edge, decimation 128
    noiseOn <= 1'b0;
    wr(8'hB5, 8'h50);
    wr(8'hB4, 8'h00);
    regWrite <= 1'b0;
    evQ.push_back(12'h401);
    pinLevel <= 1'b1;
    cycN = 0;
    do
    begin
      @(posedge clk);
      cycN++;
    end
    while (!anyTrig && cycN < 2000);
    // (16 + 128) ticks of six clocks, plus tick phase and start latency
    check("cycles", 13'h360, (cycN >= 863 && cycN <= 868) ? 13'h360 : 13'(cycN));
    if (cycN == 2000)
      closeOut();
    drain("ext_pin");
    rd(8'hB5, 8'h51);
    drain("tail");
    closeOut();
  end
endmodule // adc_sequence_controller_tb
